// ==== common/ifsb_pkg.sv ====
// ifsb_pkg: register map, field layout and carrier types for the
// interrupt flag status bank.
// assumes an APB slave with 32-bit data, one register per aligned word.
package ifsb_pkg;

    // register byte offsets on the APB window
    localparam logic [7:0] FLAGS0_OFF   = 8'h00;  // irq_flags_0
    localparam logic [7:0] FLAGS1_OFF   = 8'h04;  // irq_flags_1
    localparam logic [7:0] FLAGS3_OFF   = 8'h08;  // irq_flags_3
    localparam logic [7:0] FLAGS4_OFF   = 8'h0C;  // irq_flags_4
    localparam logic [7:0] ENABLE0_OFF  = 8'h10;  // enable for flags 0
    localparam logic [7:0] ENABLE1_OFF  = 8'h14;  // enable for flags 1
    localparam logic [7:0] ENABLE3_OFF  = 8'h18;  // enable for flags 3
    localparam logic [7:0] ENABLE4_OFF  = 8'h1C;  // enable for flags 4
    localparam logic [7:0] STATUS_OFF   = 8'h20;  // sticky event status
    localparam logic [7:0] MASK_OFF     = 8'h24;  // status mask

    // implemented-bit masks per flag register
    localparam logic [15:0] FLAGS0_IMPL = 16'hBF8F;
    localparam logic [15:0] FLAGS1_IMPL = 16'hE01F;
    localparam logic [15:0] FLAGS3_IMPL = 16'h4000;
    localparam logic [15:0] FLAGS4_IMPL = 16'h210E;

    // values after power-on reset
    localparam logic [15:0] FLAGS_RESET = 16'h0000;
    localparam logic [15:0] ENABLE_RESET = 16'h0000;
    localparam logic [3:0]  STATUS_RESET = 4'h0;

    // number of flag registers in the bank
    localparam int NUM_BANKS = 4;

    // per-source event strobes, grouped by flag register
    typedef struct packed {
        logic nonvolatile_mem_flag;   // bit 15
        logic converter_done_flag;    // bit 13
        logic serial1_tx_flag;        // bit 12
        logic serial1_rx_flag;        // bit 11
        logic spi_event_flag;         // bit 10
        logic spi_fault_flag;         // bit 9
        logic timer3_flag;            // bit 8
        logic timer2_flag;            // bit 7
        logic timer1_flag;            // bit 3
        logic compare_ch1_flag;       // bit 2
        logic capture_ch1_flag;       // bit 1
        logic ext_pin0_flag;          // bit 0
    } ifsb_src0_t;

    typedef struct packed {
        logic serial2_tx_flag;        // bit 15
        logic serial2_rx_flag;        // bit 14
        logic ext_pin2_flag;          // bit 13
        logic ext_pin1_flag;          // bit 4
        logic pin_change_flag;        // bit 3
        logic comparator_flag;        // bit 2
        logic i2c_master_event_flag;  // bit 1
        logic i2c_slave_event_flag;   // bit 0
    } ifsb_src1_t;

    typedef struct packed {
        logic calendar_clock_flag;    // bit 14 of flags 3
        logic charge_timing_flag;     // bit 13 of flags 4
        logic voltage_detect_flag;    // bit 8
        logic crc_gen_flag;           // bit 3
        logic serial2_error_flag;     // bit 2
        logic serial1_error_flag;     // bit 1
    } ifsb_src34_t;

    // all event strobes together
    typedef struct packed {
        ifsb_src0_t  src0;
        ifsb_src1_t  src1;
        ifsb_src34_t src34;
    } ifsb_events_t;

endpackage

// ==== hw/ifsb_flag_reg.sv ====
// ifsb_flag_reg: one 16-bit flag register with hardware set and
// software load, plus per-bit forwarding through an enable.
// assumes events and writes are synchronous to pclk.
`timescale 1ns/10ps

module ifsb_flag_reg #(
    parameter logic [15:0] IMPL = 16'hFFFF  // implemented bits
) (
    input  wire logic        pclk,      // system clock
    input  wire logic        presetn,   // async reset, active low
    input  wire logic [15:0] hw_set,    // one-cycle event strobes
    input  wire logic        sw_wr,     // software write strobe
    input  wire logic [15:0] sw_data,   // software write value
    input  wire logic [15:0] enable,    // forward enables
    output logic      [15:0] flags,     // flag contents
    output logic      [15:0] request    // enabled pending requests
);

    ////////////////////////////////////////////////////////////////////
    // per-bit flag storage
    genvar b;
    generate
        for (b = 0; b < 16; b++) begin : g_bit
            if (IMPL[b]) begin : g_impl
                // set beats a same-cycle software write
                always_ff @(posedge pclk or negedge presetn) begin
                    if (!presetn) begin
                        flags[b] <= 1'b0;
                    end else if (hw_set[b]) begin
                        flags[b] <= 1'b1;
                    end else if (sw_wr) begin
                        flags[b] <= sw_data[b];
                    end
                end
            end else begin : g_unimpl
                // hole in the map: always zero; a flop of its own so
                // no bit of flags mixes procedural and continuous drive
                always_ff @(posedge pclk or negedge presetn) begin
                    if (!presetn) begin
                        flags[b] <= 1'b0;
                    end else begin
                        flags[b] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // requests reach the cpu only when enabled
    assign request = flags & enable & IMPL;

endmodule // ifsb_flag_reg

// ==== hw/ifsb_bank.sv ====
// ifsb_bank: interrupt flag status bank behind an apb slave.
// assumes event sources give one-cycle strobes on pclk, and the
// cpu-side interrupt logic consumes the per-flag request outputs.
//
// Operation
// - flags0 high byte: nvm, adc, uart1, spi, timer3
// - flags0 low byte: timer2, timer1, oc1, ic1, pin0
// - flags1 bits 15-13: uart2 tx/rx, pin2
// - flags1 bits 4-0: pin1, change, comparator, i2c
// - flags3 holds only calendar clock bit 14
// - flag reads one while request pending
// - hardware sets flags; software still reads/writes
// - unimplemented bits read zero, ignore writes
// - request forwarded only when enable set
`timescale 1ns/10ps

module ifsb_bank (
    input  wire logic                  pclk,     // 10 MHz system clock
    input  wire logic                  presetn,  // async reset, low
    input  wire logic                  psel,     // apb select
    input  wire logic                  penable,  // apb access phase
    input  wire logic                  pwrite,   // apb direction
    input  wire logic [7:0]            paddr,    // apb byte address
    input  wire logic [31:0]           pwdata,   // apb write data
    output logic      [31:0]           prdata,   // apb read data
    output logic                       pready,   // apb ready
    output logic                       pslverr,  // apb error
    input  wire ifsb_pkg::ifsb_events_t events,  // source strobes
    output logic      [15:0]           req0,     // requests, flags 0
    output logic      [15:0]           req1,     // requests, flags 1
    output logic      [15:0]           req3,     // requests, flags 3
    output logic      [15:0]           req4,     // requests, flags 4
    output logic                       irq       // summary interrupt
);

    ////////////////////////////////////////////////////////////////////
    // bus decode
    logic        acc;          // access phase of a transfer
    logic        wr_en;        // write takes effect this edge
    logic        rd_en;        // read data taken this edge
    logic        hit;          // address is mapped
    logic [15:0] wdat;         // write data, low half

    assign acc     = psel & penable;
    assign wr_en   = acc & pwrite & hit;
    assign rd_en   = acc & ~pwrite & hit;
    assign wdat    = pwdata[15:0];
    // zero wait states: every access completes in its first cycle
    assign pready  = 1'b1;
    assign pslverr = acc & ~hit;   // unmapped offsets flag an error

    always_comb begin
        unique case (paddr)
            ifsb_pkg::FLAGS0_OFF, ifsb_pkg::FLAGS1_OFF,
            ifsb_pkg::FLAGS3_OFF, ifsb_pkg::FLAGS4_OFF,
            ifsb_pkg::ENABLE0_OFF, ifsb_pkg::ENABLE1_OFF,
            ifsb_pkg::ENABLE3_OFF, ifsb_pkg::ENABLE4_OFF,
            ifsb_pkg::STATUS_OFF, ifsb_pkg::MASK_OFF: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // map source strobes onto bit positions
    logic [15:0] set0;   // strobes for flags 0
    logic [15:0] set1;   // strobes for flags 1
    logic [15:0] set3;   // strobes for flags 3
    logic [15:0] set4;   // strobes for flags 4

    // flags 0 layout, bit 14 and bits 6-4 stay empty
    assign set0 = {events.src0.nonvolatile_mem_flag, 1'b0,
                   events.src0.converter_done_flag,
                   events.src0.serial1_tx_flag,
                   events.src0.serial1_rx_flag,
                   events.src0.spi_event_flag,
                   events.src0.spi_fault_flag,
                   events.src0.timer3_flag,
                   events.src0.timer2_flag, 3'b000,
                   events.src0.timer1_flag,
                   events.src0.compare_ch1_flag,
                   events.src0.capture_ch1_flag,
                   events.src0.ext_pin0_flag};

    // flags 1 layout, bits 12-5 empty
    assign set1 = {events.src1.serial2_tx_flag,
                   events.src1.serial2_rx_flag,
                   events.src1.ext_pin2_flag, 8'h00,
                   events.src1.ext_pin1_flag,
                   events.src1.pin_change_flag,
                   events.src1.comparator_flag,
                   events.src1.i2c_master_event_flag,
                   events.src1.i2c_slave_event_flag};

    // flags 3 carries the calendar clock alone
    assign set3 = {1'b0, events.src34.calendar_clock_flag,
                   14'h0000};

    // flags 4 layout
    assign set4 = {2'b00, events.src34.charge_timing_flag,
                   4'h0, events.src34.voltage_detect_flag,
                   4'h0, events.src34.crc_gen_flag,
                   events.src34.serial2_error_flag,
                   events.src34.serial1_error_flag, 1'b0};

    ////////////////////////////////////////////////////////////////////
    // forward enables, software only
    logic [15:0] en0;   // enables for flags 0
    logic [15:0] en1;   // enables for flags 1
    logic [15:0] en3;   // enables for flags 3
    logic [15:0] en4;   // enables for flags 4

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en0 <= ifsb_pkg::ENABLE_RESET;
            en1 <= ifsb_pkg::ENABLE_RESET;
            en3 <= ifsb_pkg::ENABLE_RESET;
            en4 <= ifsb_pkg::ENABLE_RESET;
        end else if (wr_en) begin
            // enables only exist where a flag exists
            if (paddr == ifsb_pkg::ENABLE0_OFF) begin
                en0 <= wdat & ifsb_pkg::FLAGS0_IMPL;
            end
            if (paddr == ifsb_pkg::ENABLE1_OFF) begin
                en1 <= wdat & ifsb_pkg::FLAGS1_IMPL;
            end
            if (paddr == ifsb_pkg::ENABLE3_OFF) begin
                en3 <= wdat & ifsb_pkg::FLAGS3_IMPL;
            end
            if (paddr == ifsb_pkg::ENABLE4_OFF) begin
                en4 <= wdat & ifsb_pkg::FLAGS4_IMPL;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // the four flag registers
    logic [15:0] fl0;   // flags 0 contents
    logic [15:0] fl1;   // flags 1 contents
    logic [15:0] fl3;   // flags 3 contents
    logic [15:0] fl4;   // flags 4 contents

    ifsb_flag_reg #(.IMPL(ifsb_pkg::FLAGS0_IMPL)) u_flags0 (
        .pclk    (pclk),
        .presetn (presetn),
        .hw_set  (set0),
        .sw_wr   (wr_en && paddr == ifsb_pkg::FLAGS0_OFF),
        .sw_data (wdat),
        .enable  (en0),
        .flags   (fl0),
        .request (req0)
    );

    ifsb_flag_reg #(.IMPL(ifsb_pkg::FLAGS1_IMPL)) u_flags1 (
        .pclk    (pclk),
        .presetn (presetn),
        .hw_set  (set1),
        .sw_wr   (wr_en && paddr == ifsb_pkg::FLAGS1_OFF),
        .sw_data (wdat),
        .enable  (en1),
        .flags   (fl1),
        .request (req1)
    );

    ifsb_flag_reg #(.IMPL(ifsb_pkg::FLAGS3_IMPL)) u_flags3 (
        .pclk    (pclk),
        .presetn (presetn),
        .hw_set  (set3),
        .sw_wr   (wr_en && paddr == ifsb_pkg::FLAGS3_OFF),
        .sw_data (wdat),
        .enable  (en3),
        .flags   (fl3),
        .request (req3)
    );

    ifsb_flag_reg #(.IMPL(ifsb_pkg::FLAGS4_IMPL)) u_flags4 (
        .pclk    (pclk),
        .presetn (presetn),
        .hw_set  (set4),
        .sw_wr   (wr_en && paddr == ifsb_pkg::FLAGS4_OFF),
        .sw_data (wdat),
        .enable  (en4),
        .flags   (fl4),
        .request (req4)
    );

    ////////////////////////////////////////////////////////////////////
    // sticky summary status: bit n set when the nth of flags 0, 1, 3, 4 goes
    // from no forwarded request to one, cleared by reading the status register
    logic [3:0] any_req;       // per-register request present
    logic [3:0] any_req_q;     // previous cycle copy
    logic [3:0] status;        // sticky status bits
    logic [3:0] mask;          // status mask, one lets it through
    logic       status_rd;     // status read this edge

    assign any_req   = {|req4, |req3, |req1, |req0};
    assign status_rd = rd_en && paddr == ifsb_pkg::STATUS_OFF;

    // edge history so a held request does not re-set after a read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            any_req_q <= 4'h0;
        end else begin
            any_req_q <= any_req;
        end
    end

    // new event beats the clear-on-read in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= ifsb_pkg::STATUS_RESET;
        end else begin
            status <= (status_rd ? 4'h0 : status)
                      | (any_req & ~any_req_q);
        end
    end

    // mask register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask <= ifsb_pkg::STATUS_RESET;
        end else if (wr_en && paddr == ifsb_pkg::MASK_OFF) begin
            mask <= pwdata[3:0];
        end
    end

    // level interrupt while any unmasked status bit stands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_status_q() & mask);
        end
    end

    // helper: status value after this edge
    function automatic logic [3:0] next_status_q();
        next_status_q = (status_rd ? 4'h0 : status)
                        | (any_req & ~any_req_q);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // read data mux; flags read one while pending, holes read zero
    logic [15:0] rmux;   // selected register value

    always_comb begin
        unique case (paddr)
            ifsb_pkg::FLAGS0_OFF:  rmux = fl0;
            ifsb_pkg::FLAGS1_OFF:  rmux = fl1;
            ifsb_pkg::FLAGS3_OFF:  rmux = fl3;
            ifsb_pkg::FLAGS4_OFF:  rmux = fl4;
            ifsb_pkg::ENABLE0_OFF: rmux = en0;
            ifsb_pkg::ENABLE1_OFF: rmux = en1;
            ifsb_pkg::ENABLE3_OFF: rmux = en3;
            ifsb_pkg::ENABLE4_OFF: rmux = en4;
            ifsb_pkg::STATUS_OFF:  rmux = {12'h000, status};
            ifsb_pkg::MASK_OFF:    rmux = {12'h000, mask};
            default:               rmux = 16'h0000;
        endcase
    end

    // combinational read data, valid in the access cycle
    assign prdata = {16'h0000, rmux};

endmodule // ifsb_bank

// ==== sim/ifsb_bank_monitor.sv ====
// ifsb_bank_monitor: port-level assertions for the flag bank.
// assumes it is bound into ifsb_bank and sees only its ports.
`timescale 1ns/10ps

module ifsb_bank_monitor (
    input wire logic                   pclk,
    input wire logic                   presetn,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [7:0]             paddr,
    input wire logic [31:0]            pwdata,
    input wire logic [31:0]            prdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    input wire ifsb_pkg::ifsb_events_t events,
    input wire logic [15:0]            req0,
    input wire logic [15:0]            req1,
    input wire logic [15:0]            req3,
    input wire logic [15:0]            req4,
    input wire logic                   irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;  // access phase of a transfer
    logic wr0;  // write access to flags 0 or enable 0
    assign acc = psel && penable;
    assign wr0 = acc && pwrite && (paddr == ifsb_pkg::FLAGS0_OFF
                 || paddr == ifsb_pkg::ENABLE0_OFF);
    ////////////////////////////////////////////////////////////////////
    chk_zero_wait: assert property (acc |-> pready)
        else $error("pready low in access phase");
    chk_upper_zero: assert property (acc |-> prdata[31:16] == 16'h0)
        else $error("upper read half not zero");
    chk_unmapped_err: assert property (acc && paddr > 8'h24
        |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    chk_impl_only: assert property (
        (req0 & ~ifsb_pkg::FLAGS0_IMPL) == 16'h0
        && (req1 & ~ifsb_pkg::FLAGS1_IMPL) == 16'h0
        && (req3 & ~ifsb_pkg::FLAGS3_IMPL) == 16'h0
        && (req4 & ~ifsb_pkg::FLAGS4_IMPL) == 16'h0)
        else $error("request on unimplemented bit");
    chk_req_drop: assert property (
        |($past(req0) & ~req0) |-> $past(wr0))
        else $error("request dropped without a write");
    chk_req_rise: assert property (
        |(req0 & ~$past(req0)) |-> $past(wr0 || (|events.src0)))
        else $error("request rose without event or write");
    chk_irq_fall: assert property ($fell(irq) |->
        $past(acc && paddr == ifsb_pkg::STATUS_OFF)
        || $past(acc && paddr == ifsb_pkg::MASK_OFF, 2))
        else $error("irq fell without status or mask access");
    chk_reset_clear: assert property ($rose(presetn) |->
        !irq && req0 == 16'h0 && req1 == 16'h0 && req3 == 16'h0
        && req4 == 16'h0)
        else $error("outputs not clear after reset");
    cover property (acc && pslverr);
    cover property ($rose(irq));
    cover property (|req0);
endmodule // ifsb_bank_monitor

bind ifsb_bank ifsb_bank_monitor u_ifsb_bank_monitor (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .events(events), .req0(req0),
    .req1(req1), .req3(req3), .req4(req4), .irq(irq));

// ==== sim/ifsb_event_src.sv ====
// ifsb_event_src: model of the peripheral event sources.
// assumes the bench raises fire for one cycle per wanted strobe.
`timescale 1ns/10ps

module ifsb_event_src (
    input  wire logic              pclk,    // system clock
    input  wire logic              presetn, // async reset, low
    input  wire logic [25:0]       fire,    // strobe request, packed
    output ifsb_pkg::ifsb_events_t events   // one-cycle strobes
);
    // registered so strobes leave just after an edge, never glitch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            events <= '0;
        end else begin
            events <= fire;
        end
    end
endmodule // ifsb_event_src

// ==== sim/ifsb_bank_test.sv ====
// ifsb_bank_test: apb-driven self-checking bench for the flag bank.
// assumes flag offsets 0x00..0x0C step 4, status 0x20, mask 0x24.
`timescale 1ns/10ps

module ifsb_bank_test;
    localparam logic [15:0] IMPL [4] = '{ifsb_pkg::FLAGS0_IMPL,
        ifsb_pkg::FLAGS1_IMPL, ifsb_pkg::FLAGS3_IMPL, ifsb_pkg::FLAGS4_IMPL};
    logic                   pclk = 1'b0;
    logic                   presetn = 1'b0;
    logic                   psel = 1'b0;
    logic                   penable = 1'b0;
    logic                   pwrite = 1'b0;
    logic [7:0]             paddr = 8'h00;
    logic [31:0]            pwdata = 32'h0;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    logic [25:0]            fire = 26'h0;  // strobe request to sources
    ifsb_pkg::ifsb_events_t events;
    logic [15:0]            req0;
    logic [15:0]            req1;
    logic [15:0]            req3;
    logic [15:0]            req4;
    logic                   irq;
    int                     errors = 0;
    int                     num_checks = 0;
    int                     cycles = 0;    // timeout counter
    logic [15:0]            exp [4];       // expected flag values
    logic [31:0]            rdv;           // read value
    logic                   err;           // slave error seen
    ////////////////////////////////////////////////////////////////////
    ifsb_bank u_ifsb_bank (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .events(events), .req0(req0), .req1(req1), .req3(req3),
        .req4(req4), .irq(irq));
    ifsb_event_src u_ifsb_event_src (.pclk(pclk), .presetn(presetn),
        .fire(fire), .events(events));
    // clock and a hang guard
    always #50 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 8000) begin
            errors++;
            stop_test();
        end
    end
    ////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] want);
        num_checks++;
        if (seen !== want) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, want, seen);
        end
    endtask
    // one apb transfer; ev strobes land in the access cycle
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d, input logic [25:0] ev);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        fire <= ev;
        @(posedge pclk);
        penable <= 1'b1;
        fire <= 26'h0;
        // wait for the answer; ends at the first edge that sees pready high, else the bench timeout
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] want,
                          input string what);
        apb(1'b0, a, 32'h0, 26'h0);
        check(what, rdv, want);
    endtask
    task automatic pulse(input logic [25:0] ev);
        @(posedge pclk);
        fire <= ev;
        @(posedge pclk);
        fire <= 26'h0;
        @(posedge pclk);
    endtask
    // places w packed bits, msb first, onto the set bits of impl
    function automatic logic [15:0] spread(input logic [15:0] impl,
        input logic [15:0] c, input int w);
        logic [15:0] r;
        int k;
        r = 16'h0;
        k = w - 1;
        for (int i = 15; i >= 0; i--) begin
            if (impl[i]) begin
                r[i] = c[k];
                k--;
            end
        end
        return r;
    endfunction
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 10; i++)
            rd_chk(8'(i * 4), 32'h0, "reset value");
        apb(1'b1, 8'h28, 32'hFFFFFFFF, 26'h0);
        check("unmapped err", {31'h0, err}, 32'h1);
        rd_chk(8'h28, 32'h0, "unmapped read");
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 8'(i * 4), 32'hFFFFFFFF, 26'h0);
            rd_chk(8'(i * 4), {16'h0, IMPL[i]}, "write ones");
            apb(1'b1, 8'(i * 4), 32'h0, 26'h0);
            rd_chk(8'(i * 4), 32'h0, "write zero");
        end
        $display("test access done");
        for (int k = 0; k < 26; k++) begin
            pulse(26'h1 << k);
            exp[0] = spread(IMPL[0], 16'(26'h1 << k >> 14), 12);
            exp[1] = spread(IMPL[1], 16'((26'h1 << k >> 6) & 26'hFF), 8);
            exp[2] = spread(IMPL[2], 16'((26'h1 << k >> 5) & 26'h1), 1);
            exp[3] = spread(IMPL[3], 16'((26'h1 << k) & 26'h1F), 5);
            for (int i = 0; i < 4; i++) begin
                rd_chk(8'(i * 4), {16'h0, exp[i]}, "event");
                apb(1'b1, 8'(i * 4), 32'h0, 26'h0);
            end
        end
        $display("test events done");
        apb(1'b1, 8'h00, 32'hFFFF, 26'h0);
        @(posedge pclk);
        check("req masked", {16'h0, req0}, 32'h0);
        apb(1'b1, 8'h10, 32'hFFFF, 26'h0);
        @(posedge pclk);
        check("req enabled", {16'h0, req0}, {16'h0, IMPL[0]});
        for (int i = 1; i < 4; i++) begin
            apb(1'b1, 8'(i * 4), 32'hFFFF, 26'h0);
            apb(1'b1, 8'(i * 4 + 16), 32'hFFFF, 26'h0);
        end
        @(posedge pclk);
        check("req1", {16'h0, req1}, {16'h0, IMPL[1]});
        check("req3", {16'h0, req3}, {16'h0, IMPL[2]});
        check("req4", {16'h0, req4}, {16'h0, IMPL[3]});
        for (int i = 1; i < 4; i++) begin
            apb(1'b1, 8'(i * 4 + 16), 32'h0, 26'h0);
        end
        apb(1'b1, 8'h00, 32'h0, 26'h1 << 17);
        rd_chk(8'h00, 32'h8, "set beats write");
        $display("test forward done");
        apb(1'b1, 8'h10, 32'h8, 26'h0);
        apb(1'b1, 8'h24, 32'h1, 26'h0);
        apb(1'b0, 8'h20, 32'h0, 26'h0);
        apb(1'b1, 8'h00, 32'h0, 26'h0);
        pulse(26'h1 << 17);
        repeat (3) @(posedge pclk);
        check("irq raised", {31'h0, irq}, 32'h1);
        rd_chk(8'h20, 32'h1, "status");
        repeat (2) @(posedge pclk);
        check("irq cleared", {31'h0, irq}, 32'h0);
        rd_chk(8'h20, 32'h0, "status cleared");
        apb(1'b1, 8'h24, 32'h0, 26'h0);
        apb(1'b1, 8'h00, 32'h0, 26'h0);
        pulse(26'h1 << 17);
        repeat (3) @(posedge pclk);
        check("irq masked", {31'h0, irq}, 32'h0);
        rd_chk(8'h20, 32'h1, "status masked");
        $display("test interrupt done");
        // second reset in mid-run, with a flag and an enable standing
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        check("irq after reset", {31'h0, irq}, 32'h0);
        rd_chk(8'h00, 32'h0, "flags after reset");
        rd_chk(8'h10, 32'h0, "enable after reset");
        $display("test second reset done");
        stop_test();
    end
endmodule // ifsb_bank_test
